// ---- sync_serial_pkg.sv ----
// constants and types shared by the synchronous serial port files
// assumes a 100 MHz system clock; serial clocks are sampled, not used as clocks
package sync_serial_pkg;
  localparam int WORD_BITS = 16;
  localparam int SLOT_MAX = 32;
  localparam int SLOT_MIN = 2;
  localparam int PORT_SETS = 4;
  localparam int DIV_WIDTH = 8;
  localparam logic [7:0] DIV_RESET = 8'h04;
  localparam logic [4:0] SLOTS_RESET = 5'h01;
  localparam logic [1:0] PORT_SET_RESET = 2'h0;
  localparam logic [4:0] BIT_RESET = 5'h00;

  typedef enum logic [1:0] {
    IDLE_STATE = 2'b00,
    SYNC_STATE = 2'b01,
    SHIFT_STATE = 2'b10
  } phase_type;
endpackage

// ---- serial_edge_sense.sv ----
// synchroniser and edge finder for one serial clock or frame sync line
// input is asynchronous to clk; two flip-flops precede any logic
module serial_edge_sense (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pinIn,
  input wire logic invert,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sense_type;

  sense_type state;
  sense_type next_state;

  // first stage feeds only the second; polarity applied after the pair
  always_comb begin
    next_state = state;
    next_state.meta = pinIn;
    next_state.sync = state.meta;
    next_state.last = state.sync ^ invert;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign level = state.sync ^ invert;
  assign rise = ce & level & ~state.last;
  assign fall = ce & ~level & state.last;
endmodule

// ---- sync_serial_port.sv ----
// synchronous serial port: transmit and receive sections with TDM framing
// How it works
// - synchronous mode: both sections use the transmit bit clock and frame sync
// - asynchronous mode: each section uses its own bit clock and frame sync
// - continuous clock: internal bit clock toggles always
// - gated clock: internal bit clock toggles only while a word moves
// - normal framing: one word each way per frame sync
// - network framing: 2 to 32 word slots per frame
// - gated clock with network framing is refused; clock held low, both sections idle
// - pins routed to one of four port sets
// - synchronous receive samples data on falling transmit bit clock
// - asynchronous receive samples data on falling receive bit clock
// - transmit data changes after rising clock; released when idle
// - frame sync changes on rising edge; one bit or one word long
// - clocks and frame syncs internal or external in either mode
// - per-section polarity inversion of clock and frame sync; zero is normal
// assumes external clocks are far slower than clk (over 4 clk periods each phase)
module sync_serial_port
  import sync_serial_pkg::*;
#(
  parameter int WORDS = WORD_BITS,
  parameter int SETS = PORT_SETS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic syncMode,
  input wire logic gatedClock,
  input wire logic networkMode,
  input wire logic [4:0] slotCount,
  input wire logic wordLengthSync,
  input wire logic txClockInternal,
  input wire logic rxClockInternal,
  input wire logic txClockPolarity,
  input wire logic rxClockPolarity,
  input wire logic txFrameSyncInvert,
  input wire logic rxFrameSyncInvert,
  input wire logic [7:0] clockDivide,
  input wire logic [1:0] portSelect,
  input wire logic [WORDS-1:0] txWord,
  input wire logic txWordValid,
  output logic txWordReady,
  output logic [WORDS-1:0] rxWord,
  output logic rxWordValid,
  output logic configError,
  input wire logic [SETS-1:0] txBitClockIn,
  output logic [SETS-1:0] txBitClockOut,
  output logic [SETS-1:0] txBitClockOe,
  input wire logic [SETS-1:0] txFrameSyncIn,
  output logic [SETS-1:0] txFrameSyncOut,
  output logic [SETS-1:0] txFrameSyncOe,
  input wire logic [SETS-1:0] rxBitClockIn,
  output logic [SETS-1:0] rxBitClockOut,
  output logic [SETS-1:0] rxBitClockOe,
  input wire logic [SETS-1:0] rxFrameSyncIn,
  output logic [SETS-1:0] rxFrameSyncOut,
  output logic [SETS-1:0] rxFrameSyncOe,
  output logic [SETS-1:0] serialTxData,
  output logic [SETS-1:0] serialTxDataOe,
  input wire logic [SETS-1:0] serialRxData
);
  typedef struct packed {
    logic [7:0] div;
    logic clkOut;
    logic fsOut;
    phase_type txPhase;
    phase_type rxPhase;
    logic [4:0] txBit;
    logic [4:0] rxBit;
    logic [4:0] txSlot;
    logic [4:0] rxSlot;
    logic [WORDS-1:0] txShift;
    logic [WORDS-1:0] rxShift;
    logic txDrive;
    logic txOut;
    logic [WORDS-1:0] rxWord;
    logic rxValid;
    logic [1:0] rxd1;
    logic [1:0] rxd2;
  } port_type;

  port_type state;
  port_type next_state;
  logic txCk, rxCk, txFs, rxFs;
  logic txCkRise, txCkFall, rxCkFall, txFsLvl, rxFsLvl;
  logic unusedA, unusedB, unusedC, unusedD;
  logic badCombo, lastBit, rxLastBit, gateOn, frameNow, rxFrameNow;
  logic rxSample, rxFall, rxFsSel;
  logic [4:0] lastSlot;

  // route the selected port set's inputs in; internal sources carry pin polarity so the sense undoes it alike
  assign txCk = txClockInternal ? (state.clkOut ^ txClockPolarity) : txBitClockIn[portSelect];
  assign rxCk = rxClockInternal ? (state.clkOut ^ rxClockPolarity) : rxBitClockIn[portSelect];
  assign txFs = txClockInternal ? (state.fsOut ^ txFrameSyncInvert) : txFrameSyncIn[portSelect];
  assign rxFs = rxClockInternal ? (state.fsOut ^ rxFrameSyncInvert) : rxFrameSyncIn[portSelect];

  // polarity undone after sampling so the core sees normal sense
  serial_edge_sense txClkSense (.clk(clk), .rst(rst), .ce(ce), .pinIn(txCk),
    .invert(txClockPolarity), .level(unusedA), .rise(txCkRise), .fall(txCkFall));
  serial_edge_sense rxClkSense (.clk(clk), .rst(rst), .ce(ce), .pinIn(rxCk),
    .invert(rxClockPolarity), .level(unusedB), .rise(), .fall(rxCkFall));
  serial_edge_sense txFsSense (.clk(clk), .rst(rst), .ce(ce), .pinIn(txFs),
    .invert(txFrameSyncInvert), .level(txFsLvl), .rise(unusedC), .fall());
  serial_edge_sense rxFsSense (.clk(clk), .rst(rst), .ce(ce), .pinIn(rxFs),
    .invert(rxFrameSyncInvert), .level(rxFsLvl), .rise(unusedD), .fall());

  // gated clock cannot serve several slots
  assign badCombo = gatedClock & networkMode;
  assign configError = badCombo;
  assign lastSlot = networkMode ? ((slotCount < 5'(SLOT_MIN - 1)) ? 5'(SLOT_MIN - 1) : slotCount) : 5'h00;
  assign lastBit = state.txBit == 5'(WORDS - 1);
  assign rxLastBit = state.rxBit == 5'(WORDS - 1);
  assign gateOn = !gatedClock || state.txPhase != IDLE_STATE || txWordValid;
  assign frameNow = txFsLvl;
  // receive follows the transmit clock and sync in synchronous mode
  assign rxFall = syncMode ? txCkFall : rxCkFall;
  assign rxFsSel = syncMode ? txFsLvl : rxFsLvl;
  assign rxFrameNow = rxFsSel;
  assign rxSample = syncMode ? state.rxd2[1] : state.rxd2[1];
  assign txWordReady = enable && !badCombo && state.txPhase == SYNC_STATE && txCkRise && state.txSlot == 5'h00;

  always_comb begin
    next_state = state;
    next_state.rxValid = 1'b0;
    // data line synchroniser: two flops, only the second is read
    next_state.rxd1 = {1'b0, serialRxData[portSelect]};
    next_state.rxd2 = {state.rxd1[0], 1'b0};
    // internal clock divider, both phases; frozen in gated idle
    if (!enable || badCombo || !gateOn) begin
      next_state.div = 8'h00;
      if (!enable || badCombo) begin
        next_state.clkOut = 1'b0;
      end
    end else if (state.div >= clockDivide) begin
      next_state.div = 8'h00;
      next_state.clkOut = ~state.clkOut;
    end else begin
      next_state.div = state.div + 8'h01;
    end
    // transmit: changes only on rising bit clock
    if (!enable || badCombo) begin
      next_state.txPhase = IDLE_STATE;
      next_state.txDrive = 1'b0;
      next_state.fsOut = 1'b0;
      next_state.txBit = BIT_RESET;
      next_state.txSlot = 5'h00;
    end else if (txCkRise) begin
      unique case (state.txPhase)
        IDLE_STATE: begin
          next_state.txDrive = 1'b0;
          if (txWordValid || !gatedClock) begin
            next_state.txPhase = SYNC_STATE;
            next_state.fsOut = 1'b1;
          end
        end
        SYNC_STATE: begin
          // frame sync seen, or tx clock external: first bit goes out on this rising edge
          next_state.txShift = (state.txSlot == 5'h00) ? txWord : state.txShift;
          if (frameNow || !txClockInternal) begin
            next_state.txPhase = SHIFT_STATE;
            next_state.txBit = BIT_RESET;
            next_state.txDrive = txWordValid || state.txSlot != 5'h00;
            next_state.txOut = next_state.txShift[WORDS-1];
            next_state.txShift = {next_state.txShift[WORDS-2:0], 1'b0};
            next_state.fsOut = wordLengthSync && state.txSlot == 5'h00;
          end
        end
        SHIFT_STATE: begin
          next_state.fsOut = wordLengthSync ? state.fsOut : 1'b0;
          if (lastBit) begin
            next_state.fsOut = 1'b0;
            if (state.txSlot != lastSlot) begin
              next_state.txSlot = state.txSlot + 5'h01;
              next_state.txBit = BIT_RESET;
              next_state.txOut = 1'b0;
            end else begin
              next_state.txSlot = 5'h00;
              next_state.txDrive = 1'b0;
              next_state.txPhase = gatedClock ? IDLE_STATE : SYNC_STATE;
              next_state.fsOut = !gatedClock;
            end
          end else begin
            next_state.txBit = state.txBit + 5'h01;
            next_state.txOut = state.txShift[WORDS-1];
            next_state.txShift = {state.txShift[WORDS-2:0], 1'b0};
          end
        end
        default: next_state.txPhase = IDLE_STATE;
      endcase
    end
    // receive: samples on the falling edge of its chosen clock
    if (!enable || badCombo) begin
      next_state.rxPhase = IDLE_STATE;
      next_state.rxBit = BIT_RESET;
      next_state.rxSlot = 5'h00;
    end else if (rxFall && state.rxPhase != SHIFT_STATE && rxFrameNow) begin
      // frame sync judged at the falling edge, where it is steady whoever drives it
      next_state.rxPhase = SHIFT_STATE;
      next_state.rxBit = BIT_RESET;
    end else if (rxFall && state.rxPhase == SHIFT_STATE) begin
      next_state.rxShift = {state.rxShift[WORDS-2:0], rxSample};
      next_state.rxBit = state.rxBit + 5'h01;
      if (rxLastBit) begin
        next_state.rxWord = {state.rxShift[WORDS-2:0], rxSample};
        next_state.rxValid = 1'b1;
        next_state.rxBit = BIT_RESET;
        if (state.rxSlot != lastSlot) begin
          next_state.rxSlot = state.rxSlot + 5'h01;
        end else begin
          next_state.rxSlot = 5'h00;
          next_state.rxPhase = IDLE_STATE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // drive only the selected port set; oe is active low
  always_comb begin
    for (int i = 0; i < SETS; i++) begin
      txBitClockOut[i] = state.clkOut ^ txClockPolarity;
      rxBitClockOut[i] = state.clkOut ^ rxClockPolarity;
      txFrameSyncOut[i] = state.fsOut ^ txFrameSyncInvert;
      rxFrameSyncOut[i] = state.fsOut ^ rxFrameSyncInvert;
      serialTxData[i] = state.txOut;
      txBitClockOe[i] = !(i == int'(portSelect) && txClockInternal && enable && !rst);
      txFrameSyncOe[i] = !(i == int'(portSelect) && txClockInternal && enable && !rst);
      rxBitClockOe[i] = !(i == int'(portSelect) && rxClockInternal && !syncMode && enable && !rst);
      rxFrameSyncOe[i] = !(i == int'(portSelect) && rxClockInternal && !syncMode && enable && !rst);
      serialTxDataOe[i] = !(i == int'(portSelect) && state.txDrive);
    end
  end

  assign rxWord = state.rxWord;
  assign rxWordValid = state.rxValid;
endmodule

// ---- sync_serial_checker.sv ----
// concurrent checks on the serial port's top-level pins
// assumes bound into every sync_serial_port instance; internal tx clock when clock rules apply
module sync_serial_checker
  import sync_serial_pkg::*;
#(
  parameter int SETS = PORT_SETS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic gatedClock,
  input wire logic networkMode,
  input wire logic txClockInternal,
  input wire logic txClockPolarity,
  input wire logic [7:0] clockDivide,
  input wire logic [1:0] portSelect,
  input wire logic txWordReady,
  input wire logic rxWordValid,
  input wire logic configError,
  input wire logic [SETS-1:0] txBitClockOut,
  input wire logic [SETS-1:0] txBitClockOe,
  input wire logic [SETS-1:0] serialTxData,
  input wire logic [SETS-1:0] serialTxDataOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic lvl;
  logic prevLvl;
  logic [7:0] sinceTog;
  logic [7:0] sinceRise;
  assign lvl = txBitClockOut[portSelect] ^ txClockPolarity;
  // cycles since the selected clock last moved; saturate so long idles never wrap
  always_ff @(posedge clk) begin
    prevLvl <= lvl;
    if (rst || !enable || lvl != prevLvl) sinceTog <= 8'h00;
    else if (sinceTog != 8'hFF) sinceTog <= sinceTog + 8'h01;
    if (lvl && !prevLvl) sinceRise <= 8'h00;
    else if (sinceRise != 8'hFF) sinceRise <= sinceRise + 8'h01;
  end
  config_refused_a: assert property (configError == (gatedClock && networkMode))
    else $error("config error flag wrong");
  refused_idle_a: assert property (configError [*4] |-> &serialTxDataOe && !rxWordValid)
    else $error("refused mode not idle");
  one_set_a: assert property ((txBitClockOe | (SETS'(1) << portSelect)) == '1)
    else $error("unselected port set driven");
  reset_release_a: assert property ($past(rst) |-> &txBitClockOe && &serialTxDataOe)
    else $error("pins driven out of reset");
  rx_pulse_a: assert property (rxWordValid |=> !rxWordValid)
    else $error("receive valid longer than one cycle");
  ready_pulse_a: assert property (txWordReady |=> !txWordReady)
    else $error("ready longer than one cycle");
  idle_release_a: assert property (!enable [*4] |-> &serialTxDataOe)
    else $error("data driven while idle");
  clock_runs_a: assert property (enable && txClockInternal && !gatedClock && !configError
    |-> sinceTog <= clockDivide + 8'h04) else $error("continuous clock stalled");
  launch_rise_a: assert property (enable && txClockInternal && !serialTxDataOe[portSelect]
    && $past(!serialTxDataOe[portSelect]) && $changed(serialTxData[portSelect]) |-> sinceRise < 8'h07)
    else $error("data changed away from rising edge");
endmodule
bind sync_serial_port sync_serial_checker #(.SETS(SETS)) chk (.*);

// ---- codec_model.sv ----
// behavioural codec on the far side of the selected port set
// assumes pins arrive with polarity removed; makes the rx link clock itself when extRx is high
module codec_model
  import sync_serial_pkg::*;
#(
  parameter int WORDS = WORD_BITS
) (
  input wire logic tck,
  input wire logic tfs,
  input wire logic txd,
  input wire logic extRx,
  input wire logic [4:0] slots,
  input wire logic [WORDS-1:0] sendWord,
  output logic rck,
  output logic rfs,
  output logic rxd = 1'b0,
  output logic [WORDS-1:0] got = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic eck;
  logic efs;
  assign eck = extRx ? rck : tck;
  assign efs = extRx ? rfs : tfs;
  // frame starts at the falling edge inside the sync bit, then one bit each period
  always @(negedge eck) begin
    if (cnt > 0) begin
      got <= {got[WORDS-2:0], txd};
      cnt <= cnt - 1;
    end else if (efs === 1'b1) begin
      cnt <= WORDS * (slots + 1);
    end
  end
  // change on rising so data is steady at the sampling edge; idle toggles the line on every rising edge
  always @(posedge eck) begin
    if (cnt > 0) rxd <= sendWord[(cnt - 1) % WORDS];
    else rxd <= ~rxd;
  end
  // link clock stands still between frames; sync moves on rising edges only
  initial begin
    rck = 1'b0;
    rfs = 1'b0;
    forever begin
      wait (extRx);
      #400;
      for (int i = 0; i <= WORDS; i++) begin
        rck = 1'b1;
        rfs = (i == 0);
        #80;
        rck = 1'b0;
        #80;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench: word exchanges through each port set and mode
// assumes codec_model on the selected set; internal tx clock at clk/16
module tb_top;
  import sync_serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst, ce, enable, syncMode, gatedClock, networkMode, wordLengthSync, txClockInternal;
  logic rxClockInternal, txClockPolarity, rxClockPolarity, txFrameSyncInvert, rxFrameSyncInvert;
  logic txWordValid, txWordReady, rxWordValid, configError, extRx, rck, rfs, rxd;
  logic [4:0] slotCount;
  logic [7:0] clockDivide;
  logic [1:0] portSelect;
  logic [WORD_BITS-1:0] txWord, rxWord, sendWord, got;
  logic [PORT_SETS-1:0] txBitClockIn, txBitClockOut, txBitClockOe, txFrameSyncIn, txFrameSyncOut, txFrameSyncOe;
  logic [PORT_SETS-1:0] rxBitClockIn, rxBitClockOut, rxBitClockOe, rxFrameSyncIn, rxFrameSyncOut, rxFrameSyncOe;
  logic [PORT_SETS-1:0] serialTxData, serialTxDataOe, serialRxData;
  int failures = 0;
  int num_checks = 0;
  // pins looped back to the partner; rx link clock comes from the partner
  assign txBitClockIn = txBitClockOut;
  assign txFrameSyncIn = txFrameSyncOut;
  assign rxBitClockIn = {PORT_SETS{rck ^ rxClockPolarity}};
  assign rxFrameSyncIn = {PORT_SETS{rfs ^ rxFrameSyncInvert}};
  assign serialRxData = {PORT_SETS{rxd}};
  sync_serial_port uut (.*);
  codec_model partner (.tck(txBitClockOut[portSelect] ^ txClockPolarity),
    .tfs(txFrameSyncOut[portSelect] ^ txFrameSyncInvert), .txd(serialTxData[portSelect]), .extRx(extRx),
    .slots(networkMode ? slotCount : 5'h00), .sendWord(sendWord), .rck(rck), .rfs(rfs), .rxd(rxd), .got(got));
  always #5 clk = ~clk;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for one received word
  task automatic waitv();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (rxWordValid !== 1'b1 && i < 1500);
    if (i >= 1500) check("rxWordValid", 32'h0, 32'h1);
  endtask
  // first n words may be partial after enable, so the next n are judged
  task automatic frame(input logic [15:0] tw, input logic [15:0] rw, input int n, input bit tx);
    txWord = tw;
    sendWord = rw;
    txWordValid = 1'b1;
    enable = 1'b1;
    repeat (n) waitv();
    repeat (n) begin
      waitv();
      check("rxWord", 32'(rxWord), 32'(rw));
    end
    if (tx) check("txWord", 32'(got), 32'(tw));
    enable = 1'b0;
    txWordValid = 1'b0;
    repeat (40) @(posedge clk);
    #1;
  endtask
  initial begin
    {rst, ce, syncMode, txClockInternal, rxClockInternal} = 5'h1F;
    {enable, gatedClock, networkMode, wordLengthSync, txWordValid, extRx} = 6'h00;
    {txClockPolarity, rxClockPolarity, txFrameSyncInvert, rxFrameSyncInvert} = 4'h0;
    {slotCount, clockDivide, portSelect, txWord, sendWord} = '0;
    clockDivide = 8'h07;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    check("serialTxDataOe", 32'(serialTxDataOe), 32'hF);
    for (int p = 0; p < 4; p++) begin
      portSelect = 2'(p);
      txClockPolarity = p[0];
      txFrameSyncInvert = p[0];
      frame(16'hA5C3 ^ 16'(p), 16'h3C5A + 16'(p), 1, 1'b1);
    end
    networkMode = 1'b1;
    slotCount = 5'h01;
    frame(16'h0F0F, 16'hF00D, 2, 1'b0);
    gatedClock = 1'b1;
    enable = 1'b1;
    repeat (200) @(posedge clk);
    #1;
    check("configError", 32'(configError), 32'h1);
    check("refusedOe", 32'(serialTxDataOe), 32'hF);
    enable = 1'b0;
    networkMode = 1'b0;
    frame(16'h8001, 16'h7FFE, 1, 1'b1);
    {gatedClock, syncMode, rxClockInternal, extRx} = 4'h1;
    {rxClockPolarity, rxFrameSyncInvert} = 2'h3;
    frame(16'h1111, 16'hC0DE, 1, 1'b0);
    complete_run();
  end
  // hang guard well beyond the expected run time
  initial begin
    #900000;
    failures++;
    complete_run();
  end
endmodule
